//--- hdl/tcm_capture_ctrl.sv
// Capture and counter-clear timing control of one timer channel
//
// The plain strobed port and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
`include "tcm_defs.svh"

// Contract
// - Mode zero idle; codes six, seven reserved
// - Mode one: in0 rise cap0, in1 rise cap1
// - Mode two: in0 rise cap0, fall cap1
// - Mode three: flip-flop rise cap0, fall cap1
// - Mode four: no capture, in1 rise clears
// - Mode five: in0 rise cap0, in1 clears
// - Capture takes pre-clear count
// - Writing zero soft bit captures into cap0
// - Soft bit write-only, reads one
module tcm_capture_ctrl
    import tcm_pkg::*;
#(
    parameter int CNT_W = `TCM_CNT_W
) (
    input wire logic CLK,
    input wire logic RESET,
    input wire logic [`TCM_ADDR_W-1:0] ADDR,
    input wire logic [`TCM_DATA_W-1:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [`TCM_DATA_W-1:0] RDATA,
    input wire logic EDGE_INPUT_ZERO,
    input wire logic EDGE_INPUT_ONE,
    input wire logic TIMER_FLIP_FLOP_OUT,
    input wire logic [CNT_W-1:0] UP_COUNT,
    output logic COUNTER_CLEAR,
    output logic CAPTURE_ZERO_STROBE,
    output logic CAPTURE_ONE_STROBE,
    output logic [CNT_W-1:0] CAPTURE_REG_ZERO,
    output logic [CNT_W-1:0] CAPTURE_REG_ONE
);
    typedef struct packed {
        logic [2:0] capture_mode_select;
        logic rsv;
        logic [CNT_W-1:0] capture_reg_zero;
        logic [CNT_W-1:0] capture_reg_one;
        logic [`TCM_DATA_W-1:0] rdata;
    } tcm_state_t;

    tcm_state_t state;
    tcm_state_t next_state;
    tcm_src_t src;
    tcm_src_t rise;
    tcm_src_t fall;
    logic cap0_ev;
    logic cap1_ev;
    logic clr_ev;
    logic mode_wr;
    logic soft_capture_trigger;
    logic [`TCM_DATA_W-1:0] mode_rd;

    // ****************************************
    // Edge detection
    // ****************************************
    assign src.in0 = EDGE_INPUT_ZERO;
    assign src.in1 = EDGE_INPUT_ONE;
    assign src.ff = TIMER_FLIP_FLOP_OUT;

    tcm_edge_detect #(
        .N(`TCM_SRC_N)
    ) u_edge (
        .clk(CLK),
        .reset(RESET),
        .sample(src),
        .rise(rise),
        .fall(fall)
    );

    // ****************************************
    // Event selection by mode
    // ****************************************
    always_comb begin
        cap0_ev = 1'b0;
        cap1_ev = 1'b0;
        clr_ev = 1'b0;
        case (state.capture_mode_select)
            `TCM_MODE_IN01_RISE: begin
                cap0_ev = rise.in0;
                cap1_ev = rise.in1;
            end
            `TCM_MODE_IN0_BOTH: begin
                cap0_ev = rise.in0;
                cap1_ev = fall.in0;
            end
            `TCM_MODE_FF_BOTH: begin
                cap0_ev = rise.ff;
                cap1_ev = fall.ff;
            end
            `TCM_MODE_CLR_IN1: begin
                clr_ev = rise.in1;
            end
            `TCM_MODE_CAP_CLR: begin
                cap0_ev = rise.in0;
                clr_ev = rise.in1;
            end
            // Off and the reserved codes do nothing
            default: begin
                cap0_ev = 1'b0;
            end
        endcase
    end

    // ****************************************
    // Register access
    // ****************************************
    assign mode_wr = WR && (ADDR == `TCM_OFF_MODE);
    assign soft_capture_trigger = mode_wr && !WDATA[`TCM_SOFT_BIT];

    always_comb begin
        mode_rd = '0;
        mode_rd[`TCM_MODE_MSB:`TCM_MODE_LSB] = state.capture_mode_select;
        mode_rd[`TCM_RSV_BIT] = state.rsv;
        mode_rd[`TCM_SOFT_BIT] = 1'b1;
    end

    always_comb begin
        next_state = state;
        if (mode_wr) begin
            next_state.capture_mode_select = WDATA[`TCM_MODE_MSB:`TCM_MODE_LSB];
            next_state.rsv = WDATA[`TCM_RSV_BIT];
        end
        // Counter clears on this same edge, so this is the pre-clear value
        if (cap0_ev || soft_capture_trigger) begin
            next_state.capture_reg_zero = UP_COUNT;
        end
        if (cap1_ev) begin
            next_state.capture_reg_one = UP_COUNT;
        end
        // Read data valid only in the cycle after the strobe
        next_state.rdata = '0;
        if (RD) begin
            if (ADDR == `TCM_OFF_MODE) begin
                next_state.rdata = mode_rd;
            end else if (ADDR == `TCM_OFF_CAP0) begin
                next_state.rdata = {{(`TCM_DATA_W-CNT_W){1'b0}}, state.capture_reg_zero};
            end else if (ADDR == `TCM_OFF_CAP1) begin
                next_state.rdata = {{(`TCM_DATA_W-CNT_W){1'b0}}, state.capture_reg_one};
            end else begin
                next_state.rdata = '0;
            end
        end
    end

    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    // Clear is combinational so the counter resets on the capture edge
    assign COUNTER_CLEAR = clr_ev;
    assign CAPTURE_ZERO_STROBE = cap0_ev || soft_capture_trigger;
    assign CAPTURE_ONE_STROBE = cap1_ev;
    assign CAPTURE_REG_ZERO = state.capture_reg_zero;
    assign CAPTURE_REG_ONE = state.capture_reg_one;
    assign RDATA = state.rdata;

    // ****************************************
    // Assertions
    // ****************************************
    default clocking cb @(posedge CLK); endclocking
    default disable iff (RESET);

    mode_off_idle_a: assert property (
        (state.capture_mode_select == `TCM_MODE_OFF || state.capture_mode_select > `TCM_MODE_CAP_CLR)
        |-> !cap0_ev && !cap1_ev && !COUNTER_CLEAR)
        else $error("event in disabled or reserved mode");

    in1_rise_cap1_a: assert property (
        state.capture_mode_select == `TCM_MODE_IN01_RISE && $past(EDGE_INPUT_ONE) == 1'b0
        && EDGE_INPUT_ONE && $past(!RESET) |=> CAPTURE_REG_ONE == $past(UP_COUNT))
        else $error("mode one missed input one capture");

    in0_fall_cap1_a: assert property (
        state.capture_mode_select == `TCM_MODE_IN0_BOTH && $fell(EDGE_INPUT_ZERO) && $past(!RESET)
        |-> CAPTURE_ONE_STROBE ##1 CAPTURE_REG_ONE == $past(UP_COUNT))
        else $error("mode two missed falling capture");

    ff_rise_cap0_a: assert property (
        state.capture_mode_select == `TCM_MODE_FF_BOTH && $rose(TIMER_FLIP_FLOP_OUT) && $past(!RESET)
        |=> CAPTURE_REG_ZERO == $past(UP_COUNT))
        else $error("mode three missed flip-flop capture");

    clr_only_a: assert property (
        state.capture_mode_select == `TCM_MODE_CLR_IN1
        |-> COUNTER_CLEAR == rise.in1 && !cap0_ev && !cap1_ev)
        else $error("mode four clear wrong");

    cap_pre_clear_a: assert property (
        state.capture_mode_select == `TCM_MODE_CAP_CLR && cap0_ev && COUNTER_CLEAR
        |=> CAPTURE_REG_ZERO == $past(UP_COUNT))
        else $error("capture did not take pre-clear count");

    soft_cap_a: assert property (
        WR && ADDR == `TCM_OFF_MODE && !WDATA[`TCM_SOFT_BIT] |=> CAPTURE_REG_ZERO == $past(UP_COUNT))
        else $error("soft capture lost");

    soft_bit_read_a: assert property (
        RD && ADDR == `TCM_OFF_MODE |=> RDATA[`TCM_SOFT_BIT] && RDATA[`TCM_DATA_W-1:`TCM_MODE_MSB+1] == '0
        && RDATA[`TCM_MODE_MSB:`TCM_MODE_LSB] == $past(state.capture_mode_select))
        else $error("mode readback wrong");

    cap1_hold_a: assert property (
        !cap1_ev |=> $stable(CAPTURE_REG_ONE))
        else $error("capture one changed without event");

    rdata_one_cycle_a: assert property (
        !RD |=> RDATA == '0)
        else $error("read data outside its cycle");

    cap_clr_cov: cover property (
        state.capture_mode_select == `TCM_MODE_CAP_CLR && cap0_ev && COUNTER_CLEAR);
    ff_fall_cov: cover property (
        state.capture_mode_select == `TCM_MODE_FF_BOTH && cap1_ev);
    soft_cov: cover property (soft_capture_trigger && cap0_ev);
    in0_both_cov: cover property (
        state.capture_mode_select == `TCM_MODE_IN0_BOTH && cap0_ev ##[1:20] cap1_ev);
endmodule

//--- hdl/tcm_defs.svh
// Constants for the timer capture and counter-clear control block
`ifndef TCM_DEFS_SVH
`define TCM_DEFS_SVH

`define TCM_DATA_W 32
`define TCM_ADDR_W 8
`define TCM_CNT_W 16

`define TCM_OFF_MODE 8'h00
`define TCM_OFF_CAP0 8'h04
`define TCM_OFF_CAP1 8'h08

`define TCM_MODE_LSB 8
`define TCM_MODE_MSB 10
`define TCM_RSV_BIT 7
`define TCM_SOFT_BIT 6

`define TCM_MODE_RESET 3'h0
`define TCM_MODE_OFF 3'h0
`define TCM_MODE_IN01_RISE 3'h1
`define TCM_MODE_IN0_BOTH 3'h2
`define TCM_MODE_FF_BOTH 3'h3
`define TCM_MODE_CLR_IN1 3'h4
`define TCM_MODE_CAP_CLR 3'h5

`define TCM_SEL_IN0 0
`define TCM_SEL_IN1 1
`define TCM_SEL_FF 2
`define TCM_SRC_N 3

`endif

//--- hdl/tcm_pkg.sv
// Shared types of the timer capture and counter-clear control block
package tcm_pkg;
    // One sample of each edge source, also used for rise and fall strobes
    typedef struct packed {
        logic ff;
        logic in1;
        logic in0;
    } tcm_src_t;
endpackage

//--- hdl/tcm_edge_detect.sv
// Synchronous rise and fall detector for the capture edge sources
`timescale 1ns/1ps
`include "tcm_defs.svh"

module tcm_edge_detect
    import tcm_pkg::*;
#(
    parameter int N = `TCM_SRC_N
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic [N-1:0] sample,
    output logic [N-1:0] rise,
    output logic [N-1:0] fall
);
    typedef struct packed {
        logic armed;
        logic [N-1:0] prev;
    } tcm_edge_state_t;

    tcm_edge_state_t state;
    tcm_edge_state_t next_state;

    // ****************************************
    // Edge strobes
    // ****************************************
    // First cycle after reset only samples, so a pin already high is no edge
    genvar i;
    generate
        for (i = 0; i < N; i++) begin : g_bit
            assign rise[i] = state.armed & sample[i] & ~state.prev[i];
            assign fall[i] = state.armed & ~sample[i] & state.prev[i];
        end
    endgenerate

    always_comb begin
        next_state = state;
        next_state.armed = 1'b1;
        next_state.prev = sample;
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end
endmodule

//--- dv/tcm_edge_src.sv
// Model of the edge pins and the up-counter outside the capture control
`timescale 1ns/1ps
module tcm_edge_src
    import tcm_pkg::*;
#(
    parameter int CNT_W = 16
) (
    input wire logic clk,
    input wire logic reset,
    input wire tcm_src_t want,
    input wire logic clear,
    output tcm_src_t pins,
    output logic [CNT_W-1:0] count
);
    // Pins move only just after an edge, so the block sees them synchronously
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            pins <= '0;
            count <= '0;
        end else begin
            pins <= want;
            count <= clear ? '0 : count + 1'b1;
        end
    end
endmodule

//--- dv/timer_capture_mode_control_tb.sv
// Self-checking bench of the timer capture and counter-clear control
`timescale 1ns/1ps
`include "tcm_defs.svh"
module timer_capture_mode_control_tb;
    import tcm_pkg::*;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic clr, s0, s1;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic [31:0] rdata;
    logic [31:0] seed = 32'hc58a;
    logic [15:0] cnt, c0, c1, e0, e1;
    logic [2:0] mode;
    tcm_src_t want = '0;
    tcm_src_t pins, prv, r, f;
    logic [1:0] hit;
    int err_count = 0;
    int samples_checked = 0;
    int cycles = 0;

    tcm_capture_ctrl i_dut (.CLK(clk), .RESET(reset), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata),
        .EDGE_INPUT_ZERO(pins.in0), .EDGE_INPUT_ONE(pins.in1), .TIMER_FLIP_FLOP_OUT(pins.ff), .UP_COUNT(cnt),
        .COUNTER_CLEAR(clr), .CAPTURE_ZERO_STROBE(s0), .CAPTURE_ONE_STROBE(s1), .CAPTURE_REG_ZERO(c0),
        .CAPTURE_REG_ONE(c1));
    tcm_edge_src i_src (.clk(clk), .reset(reset), .want(want), .clear(clr), .pins(pins), .count(cnt));

    initial begin
        forever #50 clk = ~clk;
    end

    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction

    // Returns {capture one, capture zero} for the given edges
    function automatic logic [1:0] fire(input logic [2:0] m, input tcm_src_t ri, input tcm_src_t fa);
        case (m)
            `TCM_MODE_IN01_RISE: return {ri.in1, ri.in0};
            `TCM_MODE_IN0_BOTH: return {fa.in0, ri.in0};
            `TCM_MODE_FF_BOTH: return {fa.ff, ri.ff};
            `TCM_MODE_CAP_CLR: return {1'b0, ri.in0};
            default: return 2'b00;
        endcase
    endfunction

    always_comb begin
        r = pins & ~prv;
        f = ~pins & prv;
        hit = fire(mode, r, f);
        hit[0] = hit[0] | (wr && addr == `TCM_OFF_MODE && !wdata[`TCM_SOFT_BIT]);
    end

    // Reference state; a mode write counts from the next cycle
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            prv <= '0;
            e0 <= '0;
            e1 <= '0;
            mode <= '0;
        end else begin
            prv <= pins;
            cycles <= cycles + 1;
            if (hit[0]) e0 <= cnt;
            if (hit[1]) e1 <= cnt;
            if (wr && addr == `TCM_OFF_MODE) mode <= wdata[`TCM_MODE_MSB:`TCM_MODE_LSB];
        end
    end

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            err_count++;
            $display("BAD %s expected %h seen %h", name, exp, got);
        end
    endtask

    always @(negedge clk) begin
        if (!reset) begin
            chk("clear", {31'h0, (mode == 3'h4 || mode == 3'h5) && r.in1}, {31'h0, clr});
            chk("strobe0", {31'h0, hit[0]}, {31'h0, s0});
            chk("strobe1", {31'h0, hit[1]}, {31'h0, s1});
            chk("cap0", {16'h0, e0}, {16'h0, c0});
            chk("cap1", {16'h0, e1}, {16'h0, c1});
        end
    end

    task automatic wrt(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    task automatic rdc(input logic [7:0] a);
        logic [31:0] exp;
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        @(negedge clk);
        case (a)
            `TCM_OFF_MODE: exp = {21'h0, mode, 2'b01, 6'h0};
            `TCM_OFF_CAP0: exp = {16'h0, e0};
            `TCM_OFF_CAP1: exp = {16'h0, e1};
            default: exp = 32'h0;
        endcase
        chk("rdata", exp, rdata);
    endtask

    task automatic end_sim();
        $display("checks %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // Whole run is under a thousand cycles
    always @(posedge clk) begin
        if (cycles == 3000) begin
            err_count++;
            end_sim();
        end
    end

    initial begin
        repeat (12) @(posedge clk);
        reset <= 1'b0;
        rdc(`TCM_OFF_MODE);
        rdc(`TCM_OFF_CAP1);
        rdc(8'h0c);
        $display("test reset done");
        for (int m = 0; m < 8; m++) begin
            seed = xs(seed);
            wrt(`TCM_OFF_MODE, {seed[31:11], 3'(m), 2'b01, seed[5:0]});
            repeat (60) begin
                @(posedge clk);
                seed = xs(seed);
                want <= seed[2:0];
            end
            // Both inputs rise together, then fall while the flip-flop rises
            @(posedge clk);
            want <= 3'b000;
            @(posedge clk);
            want <= 3'b011;
            @(posedge clk);
            want <= 3'b100;
            repeat (3) @(posedge clk);
            rdc(`TCM_OFF_MODE);
            rdc(`TCM_OFF_CAP0);
            wrt(`TCM_OFF_CAP1, seed);
            rdc(`TCM_OFF_CAP1);
            // Soft capture lands on the edge where both inputs rise
            @(posedge clk);
            want <= 3'b011;
            wrt(`TCM_OFF_MODE, {21'h0, mode, 2'b00, 6'h0});
            rdc(`TCM_OFF_CAP0);
            $display("test mode %0d done", m);
        end
        end_sim();
    end
endmodule
